// *** hdl/chan_gain_alarm_pkg.sv ***
// Purpose: Shared constants for the channel select, gain and alarm source
//          register bank.
// Assumes: 16-bit registers addressed by a 7-bit register address.
// Notes:   Each number is named once here and used by name elsewhere.
package chan_gain_alarm_pkg;
  // ==========================================================================
  // Register map
  localparam logic [6:0] OFS_CHAN_SELECT_LOWER = 7'h50;
  localparam logic [6:0] OFS_CHAN_SELECT_UPPER = 7'h51;
  localparam logic [6:0] OFS_INPUT_RANGE_GAIN = 7'h52;
  localparam logic [6:0] OFS_ALARM_CLEAR_SOURCE = 7'h53;
  localparam logic [15:0] RST_CHAN_SELECT_UPPER = 16'h0000;
  localparam logic [15:0] RST_INPUT_RANGE_GAIN = 16'hffff;
  localparam logic [15:0] RST_ALARM_CLEAR_SOURCE = 16'h0004;
  // Writable bits: upper select [14:12], alarm source [14:2].
  localparam logic [15:0] MASK_CHAN_SELECT_UPPER = 16'h7000;
  localparam logic [15:0] MASK_ALARM_CLEAR_SOURCE = 16'h7ffc;
  // ==========================================================================
  // Field positions
  localparam int POS_OVERTEMP_SOURCE = 2;
  localparam int POS_SOURCE_LOW = 3;
  localparam int POS_SOURCE_HIGH = 14;
  localparam int POS_DIFF_PAIR01 = 12;
  localparam int POS_DIFF_PAIR23 = 9;
  // ==========================================================================
  // Sequencer
  localparam int NUM_CHANNELS = 16;
  localparam int NUM_SLOTS = 18;
  localparam int NUM_OUTPUTS = 12;
  localparam logic [4:0] LAST_SLOT = 5'h11;
endpackage

// *** hdl/result_store.sv ***
// Purpose: Small result memory, one word per channel.
// Assumes: Single clock; write and read may happen in the same cycle.
// Notes:   Read data come out of a register one cycle after the request.
`timescale 1ns/1ps
`default_nettype none
module result_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// *** hdl/chan_gain_alarm_regs.sv ***
// Purpose: Upper channel select, input range gain and alarm clear source
//          registers, with the conversion sequencer and output clear logic.
// Assumes: Register port, converter and alarm flags run on clk_sys.
// Notes:   The lower select register lives elsewhere and arrives as a port.
//
// What this block does
// R1: Upper select bits 14..12 enable channels 13, 14, 15 for conversion.
// R2: Sequencer visits lower bits 14..0, then upper bits 14..12.
// R3: Channel 13..15 results stored per channel as unsigned binary.
// R4: Gain register at 52h resets FFFFh; bit 15 is channel 0.
// R5: Channel 0 gain bit doubles range for single-ended 0 and pair 0/1.
// R6: Channel 2 gain bit, bit 13, covers single-ended 2 and pair 2/3.
// R7: Gain bits for channels 1, 3, 4..15 cover their single channel.
// R8: Alarm source register at 53h resets 0004h and gates clear sources.
// R9: Source bits 14..5 map channels 0..3 and temperature low/high alarms.
// R10: Bits 4, 3, 2 enable sensor faults and die over-temperature.
// R11: Output cleared when source bit, auto-clear enable and flag are one.
// R12: A masked alarm never forces any output clear.
// R13: Alarm clear applies in both automatic and manual output mode.
// R14: Alarm source bits 15, 1, 0 ignore writes and read zero.
// R15: Die over-temperature ignores auto-clear enables and clears every output.
// R16: Lower select holds channels 0..12 and two pair bits in 14..0.
// R17: Upper select bits 15 and 11..0 read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
module chan_gain_alarm_regs
  import chan_gain_alarm_pkg::*;
#(
  parameter int CODE_WIDTH = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [14:0] chan_select_lower,
  input wire logic conv_run,
  input wire logic conv_done,
  input wire logic [CODE_WIDTH-1:0] conv_code,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic conv_diff,
  output logic conv_range_double,
  output logic [15:0] range_double_ch,
  input wire logic [14:2] alarm_flags,
  input wire logic [11:0] output_auto_clear_en,
  output logic [11:0] output_clear,
  input wire logic res_rd,
  input wire logic [3:0] res_addr,
  output logic [CODE_WIDTH-1:0] res_rdata
);
  // ==========================================================================
  // State
  typedef enum logic [1:0] {SCAN, WAIT} seq_t;
  typedef struct packed {
    logic [15:0] sel_upper;
    logic [15:0] gain;
    logic [15:0] src_mask;
    logic [15:0] rdata;
    logic [4:0] slot;
    seq_t seq;
    logic start;
    logic [3:0] channel;
    logic diff;
    logic range_dbl;
    logic [11:0] clr;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic res_we;

  // Slot order: lower bits 14..0 are slots 0..14, upper 14..12 are 15..17.
  function automatic logic [3:0] slot_chan(input logic [4:0] s);
    logic [3:0] c;
    c = 4'h0;
    unique case (s)
      5'h00, 5'h02: c = 4'h0;
      5'h01: c = 4'h1;
      5'h03, 5'h05: c = 4'h2;
      5'h04: c = 4'h3;
      default: c = 4'(s - 5'h02);
    endcase
    return c;
  endfunction

  function automatic logic slot_is_diff(input logic [4:0] s);
    return (s == 5'h02) || (s == 5'h05);
  endfunction

  // R16: lower select decode
  // A pair bit only counts while both of its single-ended bits are clear.
  function automatic logic slot_on(input logic [4:0] s,
                                   input logic [14:0] lo,
                                   input logic [15:0] up);
    logic on;
    on = 1'b0;
    if (s == 5'h02) begin
      on = lo[POS_DIFF_PAIR01] & ~lo[14] & ~lo[13];
    end else if (s == 5'h05) begin
      on = lo[POS_DIFF_PAIR23] & ~lo[11] & ~lo[10];
    end else if (s < 5'h0f) begin
      on = lo[4'(5'h0e - s)];
    end else begin
      on = up[4'(5'h1d - s)];
    end
    return on;
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic [11:0] clr_any;
    clr_any = '0;
    st_next = st_reg;
    st_next.start = 1'b0;
    res_we = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        // R1: upper select
        // R17: reserved bits
        OFS_CHAN_SELECT_UPPER:
          st_next.sel_upper = reg_wdata & MASK_CHAN_SELECT_UPPER;
        // R4: gain write
        OFS_INPUT_RANGE_GAIN: st_next.gain = reg_wdata;
        // R14: reserved bits
        OFS_ALARM_CLEAR_SOURCE:
          st_next.src_mask = reg_wdata & MASK_ALARM_CLEAR_SOURCE;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CHAN_SELECT_UPPER: st_next.rdata = st_reg.sel_upper;
        OFS_INPUT_RANGE_GAIN: st_next.rdata = st_reg.gain;
        OFS_ALARM_CLEAR_SOURCE: st_next.rdata = st_reg.src_mask;
        default: st_next.rdata = 16'h0000;
      endcase
    end
    // R2: slot walk
    unique case (st_reg.seq)
      SCAN: begin
        if (conv_run &&
            slot_on(st_reg.slot, chan_select_lower, st_reg.sel_upper)) begin
          st_next.start = 1'b1;
          st_next.channel = slot_chan(st_reg.slot);
          st_next.diff = slot_is_diff(st_reg.slot);
          // R5: gain per channel
          // R6: pair uses even gain
          // R7: single channel gain
          st_next.range_dbl = st_reg.gain[4'hf - slot_chan(st_reg.slot)];
          st_next.seq = WAIT;
        end else if (conv_run) begin
          st_next.slot = (st_reg.slot == LAST_SLOT) ? 5'h00
                         : 5'(st_reg.slot + 5'h01);
        end
      end
      WAIT: begin
        if (conv_done) begin
          // R3: result stored
          res_we = 1'b1;
          st_next.slot = (st_reg.slot == LAST_SLOT) ? 5'h00
                         : 5'(st_reg.slot + 5'h01);
          st_next.seq = SCAN;
        end
      end
    endcase
    // R9: source to flag map
    // R11: three-way and
    // R12: masked alarm ignored
    // R13: no mode term
    for (int i = POS_SOURCE_LOW; i <= POS_SOURCE_HIGH; i++) begin
      if (st_reg.src_mask[i] && alarm_flags[i]) begin
        clr_any = clr_any | output_auto_clear_en;
      end
    end
    // R10: over-temperature source
    // R15: clears all outputs
    if (st_reg.src_mask[POS_OVERTEMP_SOURCE] &&
        alarm_flags[POS_OVERTEMP_SOURCE]) begin
      clr_any = '1;
    end
    st_next.clr = clr_any;
  end

  // R8: source reset value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{sel_upper: RST_CHAN_SELECT_UPPER,
                  gain: RST_INPUT_RANGE_GAIN,
                  src_mask: RST_ALARM_CLEAR_SOURCE,
                  rdata: 16'h0000, slot: 5'h00, seq: SCAN,
                  start: 1'b0, channel: 4'h0, diff: 1'b0,
                  range_dbl: 1'b0, clr: 12'h000};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = st_reg.rdata;
  assign conv_start = st_reg.start;
  assign conv_channel = st_reg.channel;
  assign conv_diff = st_reg.diff;
  assign conv_range_double = st_reg.range_dbl;
  assign output_clear = st_reg.clr;
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_gain
    assign range_double_ch[g] = st_reg.gain[NUM_CHANNELS - 1 - g];
  end

  result_store #(.WIDTH(CODE_WIDTH), .DEPTH(NUM_CHANNELS), .AW(4)) u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(res_we),
    .wr_addr(st_reg.channel),
    .wr_data(conv_code),
    .rd_en(res_rd),
    .rd_addr(res_addr),
    .rd_data(res_rdata)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_UPPER_RSV: assert property ( // R17
    (st_reg.sel_upper & ~MASK_CHAN_SELECT_UPPER) == 16'h0000)
    else $error("upper select reserved bit set");
  AST_UPPER_WR: assert property ( // R1
    reg_wr && reg_addr == OFS_CHAN_SELECT_UPPER |=>
    st_reg.sel_upper[14:12] == $past(reg_wdata[14:12]))
    else $error("upper select write lost");
  AST_SRC_RSV: assert property ( // R14
    reg_wr && reg_addr == OFS_ALARM_CLEAR_SOURCE |=>
    st_reg.src_mask == ($past(reg_wdata) & MASK_ALARM_CLEAR_SOURCE))
    else $error("alarm source write wrong");
  AST_GAIN_MAP: assert property ( // R4
    reg_wr && reg_addr == OFS_INPUT_RANGE_GAIN |=>
    range_double_ch[0] == $past(reg_wdata[15]) &&
    range_double_ch[15] == $past(reg_wdata[0]))
    else $error("gain bit order wrong");
  AST_START_RANGE: assert property ( // R7
    conv_start |-> conv_range_double == range_double_ch[conv_channel])
    else $error("range does not match channel gain");
  AST_PAIR_CHAN: assert property ( // R6
    conv_start && conv_diff |-> conv_channel == 4'h0 || conv_channel == 4'h2)
    else $error("pair converted on odd channel");
  AST_SEQ_ORDER: assert property ( // R2
    st_reg.seq == SCAN && conv_run && !st_next.start |=>
    st_reg.slot == (($past(st_reg.slot) == LAST_SLOT) ? 5'h00
                    : 5'($past(st_reg.slot) + 5'h01)))
    else $error("sequence order broken");
  AST_RESULT_WR: assert property ( // R3
    st_reg.seq == WAIT && conv_done |-> res_we ##1 st_reg.seq == SCAN)
    else $error("result not written");
  AST_CLEAR_SET: assert property ( // R11
    st_reg.src_mask[14] && alarm_flags[14] |=>
    (output_clear & $past(output_auto_clear_en)) ==
    $past(output_auto_clear_en))
    else $error("alarm did not clear enabled outputs");
  AST_OVERTEMP: assert property ( // R15
    st_reg.src_mask[2] && alarm_flags[2] |=> output_clear == 12'hfff)
    else $error("over-temperature did not clear all");
  AST_MASKED: assert property ( // R12
    (st_reg.src_mask[14:2] & alarm_flags[14:2]) == 13'h0000 |=>
    output_clear == 12'h000)
    else $error("masked alarm cleared an output");

  COV_START: cover property (conv_start ##[1:20] conv_done);
  COV_UPPER: cover property (conv_start && conv_channel == 4'hf);
  COV_CLEAR: cover property (output_clear == 12'hfff);
endmodule
`default_nettype wire

// *** verification/conv_model.sv ***
// Purpose: Converter stand-in that answers each start with a coded result.
// Assumes: One result per start pulse, answered DELAY cycles later.
// Notes:   The code bus toggles between answers, so stale data match only every other cycle.
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
  parameter int DELAY = 3
) (
  input wire logic clk_sys,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  output logic conv_done,
  output logic [11:0] conv_code
);
  // ==========================================================================
  // Answer loop
  initial begin
    conv_done = 1'b0;
    conv_code = 12'h000;
    forever begin
      @(posedge clk_sys);
      #1;
      conv_code = ~conv_code;
      if (conv_start === 1'b1) begin
        repeat (DELAY) @(posedge clk_sys);
        #1;
        conv_done = 1'b1;
        conv_code = {8'ha5, conv_channel};
        @(posedge clk_sys);
        #1;
        conv_done = 1'b0;
        conv_code = ~conv_code;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the select, gain and alarm source bank.
// Assumes: Inputs change 1 ns after the rising edge of clk_sys.
// Notes:   The converter is modelled; results carry the channel number.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import chan_gain_alarm_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, conv_run, conv_done, conv_start;
  logic conv_diff, conv_range_double, res_rd;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, range_double_ch;
  logic [14:0] chan_select_lower;
  logic [11:0] conv_code, output_auto_clear_en, output_clear, res_rdata;
  logic [3:0] conv_channel, res_addr;
  logic [14:2] alarm_flags;
  int failures = 0;
  int n_tests = 0;
  chan_gain_alarm_regs chan_gain_alarm_regs_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .chan_select_lower(chan_select_lower), .conv_run(conv_run),
    .conv_done(conv_done), .conv_code(conv_code), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_diff(conv_diff),
    .conv_range_double(conv_range_double), .range_double_ch(range_double_ch),
    .alarm_flags(alarm_flags), .output_auto_clear_en(output_auto_clear_en),
    .output_clear(output_clear), .res_rd(res_rd), .res_addr(res_addr),
    .res_rdata(res_rdata));
  conv_model conv_model_inst (.clk_sys(clk_sys), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_code(conv_code));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    chk("reg_rdata", exp, reg_rdata);
  endtask
  task automatic wait_start;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (conv_start !== 1'b1 && k < 60);
  endtask
  task automatic results;
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    rd_chk(OFS_CHAN_SELECT_UPPER, 16'h0000);
    rd_chk(OFS_INPUT_RANGE_GAIN, 16'hffff);
    rd_chk(OFS_ALARM_CLEAR_SOURCE, 16'h0004);
    chk("range_double_ch", 16'hffff, range_double_ch);
  endtask
  task automatic test_access;
    wr(OFS_CHAN_SELECT_UPPER, 16'hffff);
    rd_chk(OFS_CHAN_SELECT_UPPER, 16'h7000);
    wr(OFS_ALARM_CLEAR_SOURCE, 16'hffff);
    rd_chk(OFS_ALARM_CLEAR_SOURCE, 16'h7ffc);
    rd_chk(7'h60, 16'h0000);
    wr(OFS_INPUT_RANGE_GAIN, 16'h1234);
    rd_chk(OFS_INPUT_RANGE_GAIN, 16'h1234);
    chk("range_double_ch", 16'h2c48, range_double_ch);
  endtask
  task automatic test_alarm;
    // The die over-temperature case runs with enables off on purpose.
    for (int p = 2; p <= 14; p++) begin
      wr(OFS_ALARM_CLEAR_SOURCE, 16'(16'h0001 << p));
      alarm_flags = 13'(13'h0001 << (p - 2));
      output_auto_clear_en = (p == 2) ? 12'h000 : 12'h003;
      @(posedge clk_sys);
      #1;
      chk("output_clear", (p == 2) ? 16'h0fff : 16'h0003, {4'h0, output_clear});
      wr(OFS_ALARM_CLEAR_SOURCE, 16'h0000);
      @(posedge clk_sys);
      #1;
      chk("output_clear", 16'h0000, {4'h0, output_clear});
    end
    alarm_flags = '0;
  endtask
  task automatic test_seq;
    logic [3:0] ch[4] = '{4'h0, 4'hd, 4'he, 4'hf};
    int k;
    wr(OFS_CHAN_SELECT_UPPER, 16'h7000);
    wr(OFS_INPUT_RANGE_GAIN, 16'h8000);
    chan_select_lower = 15'h1000;
    conv_run = 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        #1;
        k++;
      end while (conv_start !== 1'b1 && k < 60);
      chk("conv_start", 16'h0001, {15'h0, conv_start});
      chk("conv_channel", {12'h0, ch[i]}, {12'h0, conv_channel});
      chk("conv_diff", (i == 0) ? 16'h1 : 16'h0, {15'h0, conv_diff});
      chk("conv_range", (i == 0) ? 16'h1 : 16'h0, {15'h0, conv_range_double});
    end
    conv_run = 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      #1;
      res_rd = 1'b1;
      res_addr = ch[i];
      @(posedge clk_sys);
      #1;
      res_rd = 1'b0;
      chk("res_rdata", {4'h0, 8'ha5, ch[i]}, {4'h0, res_rdata});
      @(posedge clk_sys);
    end
  endtask
  // Pair 2/3 first, then channel 13, then channel 2 alone once its
  // single-ended bit makes the pair bit count for nothing.
  task automatic test_pair;
    wr(OFS_CHAN_SELECT_UPPER, 16'h4000);
    wr(OFS_INPUT_RANGE_GAIN, 16'h2000);
    chan_select_lower = 15'h0200;
    conv_run = 1'b1;
    wait_start();
    chk("conv_start", 16'h0001, {15'h0, conv_start});
    chk("conv_channel", 16'h0002, {12'h0, conv_channel});
    chk("conv_diff", 16'h0001, {15'h0, conv_diff});
    chk("conv_range", 16'h0001, {15'h0, conv_range_double});
    chan_select_lower = 15'h0a00;
    wait_start();
    chk("conv_channel", 16'h000d, {12'h0, conv_channel});
    chk("conv_range", 16'h0000, {15'h0, conv_range_double});
    wait_start();
    chk("conv_channel", 16'h0002, {12'h0, conv_channel});
    chk("conv_diff", 16'h0000, {15'h0, conv_diff});
    chk("conv_range", 16'h0001, {15'h0, conv_range_double});
    conv_run = 1'b0;
  endtask
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, conv_run, res_rd} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    chan_select_lower = '0;
    alarm_flags = '0;
    output_auto_clear_en = '0;
    res_addr = '0;
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_access();
    test_alarm();
    test_seq();
    test_pair();
    results();
  end
  initial begin
    #(3000 * 100);
    failures++;
    results();
  end
endmodule
`default_nettype wire
